// ==== logic/lamp_cfg.svh ====
// Constants for the fiber node status-indicator block.
// Assumes a 100 MHz system clock and Wishbone byte addressing.
`ifndef LAMP_CFG_SVH
`define LAMP_CFG_SVH
`define CLK_HZ           100000000
`define BLINK_MS         250
`define BLINK_CYCLES     ((`CLK_HZ / 1000) * `BLINK_MS)
`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_LAMPS       8'h08
`define CTRL_RESET       32'h0000_0000
`define CTRL_MASTER_BIT  0
`define CTRL_REDUND_BIT  1
`define CTRL_MULTI_BIT   2
`define CTRL_HOLD_BIT    3
`define CTRL_CLRSEEN_BIT 4
`define CTRL_SLAVE_BIT   5
`endif

// ==== logic/lamp_pkg.sv ====
// Types for the fiber node status-indicator block.
// Assumes the constants header is included by the design file.
package lamp_pkg;
  // Two-bit lamp colour: bit 0 green, bit 1 red; both lit reads as yellow.
  typedef struct packed {
    logic red;
    logic green;
  } lamp_t;
  // Per-channel inputs that travel together.
  typedef struct packed {
    logic rx_valid;
    logic active;
    logic tx_data;
    logic rx_data;
  } chan_in_t;
  // Network fault lamp modes.
  typedef enum logic [2:0] {
    NET_OFF     = 3'b000,
    NET_GOOD    = 3'b001,
    NET_BREAK   = 3'b010,
    NET_HELD    = 3'b011,
    NET_REPAIR  = 3'b100,
    NET_CONFIG  = 3'b101
  } net_mode_t;
endpackage

// ==== logic/fiber_node_status_indicators.sv ====
// Status-indicator and fault-contact logic of a two-channel fiber node.
// Assumes asynchronous pin inputs, a Wishbone classic master on mclk.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lamp_cfg.svh"

// Lamp encoding: every two-colour lamp is a lamp_t with green in bit 0
// and red in bit 1; both lit together make yellow, neither is dark.
// Single-colour lamps, contacts and enables are plain bits, high for lit,
// closed or enabled.

// Timing: every pin is an asynchronous level. It passes two flip-flops
// and then one output register, so a change on a pin shows on the lamps
// two edges after the edge that first samples it; serial_master_seen, which also passes the mismatch latch, takes three.
// Flashing lamps follow one shared phase bit that toggles once every
// BLINK_CYCLES edges; alternating lamps show green in one half of the
// period and red in the other.
// Hazard: the blink count is long, so a short simulation sees a constant
// phase and cannot tell a flashing lamp from a dark or steady one.

// Register map on the Wishbone slave, byte addresses, bits 31:8 zero:
//   CTRL   0x00  bit 0 network master present, bit 1 redundant network,
//                bit 2 multi-master option, bit 3 hold mode, bit 4 write
//                one to forget captured failures (reads zero), bit 5
//                node configured as slave; all bits reset to zero.
//   STATUS 0x04  synchronised pins in port order from bit 31 down to
//                bit 7, the mismatch latch in bit 6, zeros below; the
//                lowest supply bit is left out to make room for the latch.
//   LAMPS  0x08  health, traffic, network lamp, contacts and transmit
//                enables from bit 15 down; bits 1:0 and 31:16 read zero.
// Every request is acknowledged one cycle after it is taken, and ack
// stands for one cycle only; the master drops cyc or stb for at least one
// cycle between requests.
// Unmapped addresses read as zero, ignore writes and are still
// acknowledged, so a stray access never hangs the bus.
// The mismatch latch survives every register write; only resetn clears
// it, which stands in for a power cycle of the node.
module fiber_node_status_indicators (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic [1:0]             rx_valid,
  input  wire logic [1:0]             chan_active,
  input  wire logic [1:0]             tx_data,
  input  wire logic [1:0]             rx_data,
  input  wire logic                   net_break,
  input  wire logic                   fail_captured,
  input  wire logic                   fail_repaired,
  input  wire logic                   serial_master_seen,
  input  wire logic [3:0]             cu_link,
  input  wire logic [3:0]             cu_tx,
  input  wire logic [3:0]             cu_rx,
  input  wire logic [1:0]             psu_online,
  input  wire logic [31:0]            wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic                   wb_we_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output lamp_pkg::lamp_t [1:0]       health_lamp,
  output lamp_pkg::lamp_t [1:0]       traffic_lamp,
  output lamp_pkg::lamp_t             net_lamp,
  output logic                        power_lamp,
  output lamp_pkg::lamp_t [3:0]       cu_dual_lamp,
  output logic      [3:0]             cu_green_lamp,
  output logic      [3:0]             cu_yellow_lamp,
  output logic      [1:0]             psu_lamp_red,
  output logic      [1:0]             rx_fault_contact,
  output logic      [1:0]             tx_enable
);
  localparam int PIN_W = 32;

  // Raw pin bundle and its two synchroniser stages.
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync1_r;
  logic [PIN_W-1:0] sync2_r;
  assign pins_raw = {rx_valid, chan_active, tx_data, rx_data, net_break,
                     fail_captured, fail_repaired, serial_master_seen,
                     cu_link, cu_tx, cu_rx, psu_online, 6'h00};

  // Two flip-flops stand between every pin and the logic.
  // Only the second stage is read by logic; the first may go metastable.
  // The spare low bits are tied to zero so the vector has a round width.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 32'h0000_0000;
      sync2_r <= 32'h0000_0000;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end

  // Synchronised views of the pins.
  logic [1:0] s_valid;
  logic [1:0] s_active;
  logic [1:0] s_tx;
  logic [1:0] s_rx;
  logic       s_break;
  logic       s_captured;
  logic       s_repaired;
  logic       s_master_seen;
  logic [3:0] s_link;
  logic [3:0] s_cutx;
  logic [3:0] s_curx;
  logic [1:0] s_psu;
  assign {s_valid, s_active, s_tx, s_rx, s_break, s_captured, s_repaired,
          s_master_seen, s_link, s_cutx, s_curx, s_psu} = sync2_r[31:6];

  // Control register and latched configuration fault.
  logic [31:0] ctrl_r;
  logic        cfg_fault_r;
  logic [1:0]  seen_fail_r;
  logic        net_master;
  logic        redundant;
  logic        multi_master_option;
  logic        hold_mode;
  logic        slave_cfg;
  assign net_master          = ctrl_r[`CTRL_MASTER_BIT];
  assign redundant           = ctrl_r[`CTRL_REDUND_BIT];
  assign multi_master_option = ctrl_r[`CTRL_MULTI_BIT];
  assign hold_mode           = ctrl_r[`CTRL_HOLD_BIT];
  assign slave_cfg           = ctrl_r[`CTRL_SLAVE_BIT];

  // Address decode shared by read and write paths.
  // Upper address bits must be zero, so aliases of the three registers
  // higher up the address space are not decoded.
  function automatic logic is_addr(input logic [31:0] a,
                                   input logic [7:0] off);
    is_addr = (a[7:0] == off) && (a[31:8] == 24'h00_0000);
  endfunction

  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Acknowledge each request one cycle after it appears.
  // The request term masks itself with ack, so a master that holds cyc and
  // stb over the acknowledge edge is not taken a second time; the ack
  // therefore stands for exactly one cycle.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Control register writes honour byte lanes; bit 4 is a self-clearing
  // strobe that forgets the captured-failure memory of both channels.
  // A write with byte lane 0 disabled leaves the low control bits alone
  // and cannot raise the clear strobe.
  logic clr_seen;
  assign clr_seen = req && wb_we_i && wb_sel_i[0] &&
                    is_addr(wb_adr_i, `ADDR_CTRL) &&
                    wb_dat_i[`CTRL_CLRSEEN_BIT];
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (req && wb_we_i && is_addr(wb_adr_i, `ADDR_CTRL)) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
      ctrl_r[`CTRL_CLRSEEN_BIT] <= 1'b0;
    end
  end

  // Read data: control, synchronised inputs, or the lamp image.
  // The word is loaded on the taking edge and held until the next read,
  // so it stands at the edge where the master sees ack.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      if (is_addr(wb_adr_i, `ADDR_CTRL)) begin
        wb_dat_o <= ctrl_r;
      end else if (is_addr(wb_adr_i, `ADDR_STATUS)) begin
        wb_dat_o <= {sync2_r[31:7], cfg_fault_r, 6'h00};
      end else if (is_addr(wb_adr_i, `ADDR_LAMPS)) begin
        wb_dat_o <= {16'h0000, health_lamp, traffic_lamp, net_lamp,
                     rx_fault_contact, tx_enable, 2'h0};
      end else begin
        // Unmapped addresses read as zero and are still acknowledged.
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Mismatch latch: only reset (power cycle) clears it.
  // It sets while the multi-master option is on, the node is configured as
  // a slave and a serial bus master is seen on the attached line. Clearing
  // the configuration bits afterwards does not release it.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_fault_r <= 1'b0;
    end else if (multi_master_option && slave_cfg && s_master_seen) begin
      cfg_fault_r <= 1'b1;
    end
  end

  // Free-running blink timer shared by every flashing pattern.
  // One phase bit serves every lamp, so flashing and alternating lamps on
  // all channels and ports stay in step with each other.
  logic [31:0] blink_cnt_r;
  logic        phase_r;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_r <= 32'h0000_0000;
      phase_r     <= 1'b0;
    end else if (blink_cnt_r == 32'(`BLINK_CYCLES - 1)) begin
      blink_cnt_r <= 32'h0000_0000;
      phase_r     <= !phase_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  // Per-channel memory of a failure seen while in hold mode; a new loss
  // of receive wins over a software clear in the same cycle.
  // Leaving hold mode forgets the memory as well, since the held
  // condition has then been reset for the whole network.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seen_fail_r <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (hold_mode && !s_valid[c]) begin
          seen_fail_r[c] <= 1'b1;
        end else if (clr_seen || !hold_mode) begin
          seen_fail_r[c] <= 1'b0;
        end
      end
    end
  end

  // Optical channel lamps, contacts and transmit enables.
  // The health lamp shows red for a missing receive before anything else,
  // then the alternating repaired pattern, then steady green.
  // The traffic lamp gives receive traffic priority over transmit traffic,
  // so a channel busy both ways flashes yellow.
  // The contact closes and the transmit output is cut on the same edge,
  // so a broken fiber is passed on to the neighbouring node.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          health_lamp[g]      <= '0;
          traffic_lamp[g]     <= '0;
          rx_fault_contact[g] <= 1'b0;
          tx_enable[g]        <= 1'b0;
        end else begin
          if (!s_valid[g]) begin
            health_lamp[g] <= '{red: 1'b1, green: 1'b0};
          end else if (seen_fail_r[g]) begin
            // Repaired but not yet reset from the held condition.
            health_lamp[g] <= '{red: phase_r, green: !phase_r};
          end else begin
            health_lamp[g] <= '{red: 1'b0, green: 1'b1};
          end
          if (!s_active[g]) begin
            traffic_lamp[g] <= '0;
          end else if (s_rx[g]) begin
            traffic_lamp[g] <= '{red: phase_r, green: phase_r};
          end else if (s_tx[g]) begin
            traffic_lamp[g] <= '{red: 1'b0, green: phase_r};
          end else begin
            traffic_lamp[g] <= '{red: 1'b0, green: 1'b1};
          end
          rx_fault_contact[g] <= !s_valid[g];
          tx_enable[g]        <= s_valid[g];
        end
      end
    end
    // Copper port lamps: the dual lamp shows link, transmit and receive,
    // the single green lamp folds both kinds of traffic into one flash,
    // and the single yellow lamp simply follows receive data.
    for (g = 0; g < 4; g++) begin : g_copper
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          cu_dual_lamp[g]   <= '0;
          cu_green_lamp[g]  <= 1'b0;
          cu_yellow_lamp[g] <= 1'b0;
        end else begin
          if (!s_link[g]) begin
            cu_dual_lamp[g] <= '0;
          end else if (s_curx[g]) begin
            cu_dual_lamp[g] <= '{red: phase_r, green: phase_r};
          end else if (s_cutx[g]) begin
            cu_dual_lamp[g] <= '{red: 1'b0, green: phase_r};
          end else begin
            cu_dual_lamp[g] <= '{red: 1'b0, green: 1'b1};
          end
          if (!s_link[g]) begin
            cu_green_lamp[g] <= 1'b0;
          end else if (s_cutx[g] || s_curx[g]) begin
            cu_green_lamp[g] <= phase_r;
          end else begin
            cu_green_lamp[g] <= 1'b1;
          end
          cu_yellow_lamp[g] <= s_curx[g];
        end
      end
    end
  endgenerate

  // Network fault lamp mode, mismatch first.
  // Order of precedence: a latched mismatch, then no network master, then
  // a captured failure in hold mode (flashing red while unrepaired,
  // alternating once repaired), then a break on a redundant network outside hold mode, then a
  // healthy redundant network. Anything else leaves the lamp dark.
  lamp_pkg::net_mode_t net_mode;
  always_comb begin
    if (cfg_fault_r) begin
      net_mode = lamp_pkg::NET_CONFIG;
    end else if (!net_master) begin
      net_mode = lamp_pkg::NET_OFF;
    end else if (hold_mode && s_captured && !s_repaired) begin
      net_mode = lamp_pkg::NET_HELD;
    end else if (hold_mode && s_captured && s_repaired) begin
      net_mode = lamp_pkg::NET_REPAIR;
    end else if (redundant && s_break && !hold_mode) begin
      net_mode = lamp_pkg::NET_BREAK;
    end else if (redundant && !s_break) begin
      net_mode = lamp_pkg::NET_GOOD;
    end else begin
      net_mode = lamp_pkg::NET_OFF;
    end
  end

  // Network lamp, power lamp and supply button lamps.
  // The power lamp lights on the first edge after reset and then stays on.
  // A supply button lamp is red exactly when its supply reports off-line.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      net_lamp     <= '0;
      power_lamp   <= 1'b0;
      psu_lamp_red <= 2'b00;
    end else begin
      case (net_mode)
        lamp_pkg::NET_GOOD:   net_lamp <= '{red: 1'b0, green: 1'b1};
        lamp_pkg::NET_BREAK:  net_lamp <= '{red: 1'b0, green: phase_r};
        lamp_pkg::NET_HELD:   net_lamp <= '{red: phase_r, green: 1'b0};
        lamp_pkg::NET_REPAIR: net_lamp <= '{red: phase_r, green: !phase_r};
        lamp_pkg::NET_CONFIG: net_lamp <= '{red: 1'b1, green: 1'b0};
        default:              net_lamp <= '0;
      endcase
      power_lamp   <= 1'b1;
      psu_lamp_red <= ~s_psu;
    end
  end
endmodule
`default_nettype wire

// ==== test/lamp_checker.sv ====
// Concurrent checks on the status-indicator block, bound to its top module.
// Assumes pin inputs reach the lamps three mclk edges after sampling.
`timescale 1ns/1ps
`default_nettype none
module lamp_checker (
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire logic [1:0]            rx_valid,
  input wire logic [1:0]            chan_active,
  input wire logic [1:0]            tx_data,
  input wire logic [1:0]            rx_data,
  input wire logic [3:0]            cu_link,
  input wire logic [3:0]            cu_rx,
  input wire logic [1:0]            psu_online,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire lamp_pkg::lamp_t [1:0] health_lamp,
  input wire lamp_pkg::lamp_t [1:0] traffic_lamp,
  input wire logic                  power_lamp,
  input wire logic [3:0]            cu_green_lamp,
  input wire logic [3:0]            cu_yellow_lamp,
  input wire logic [1:0]            psu_lamp_red,
  input wire logic [1:0]            rx_fault_contact,
  input wire logic [1:0]            tx_enable
);
  logic [2:0] up_r; // Edges since reset release; lamp checks wait for sync.

  // Counts edges after reset so checks skip the synchroniser fill.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h7) begin
      up_r <= up_r + 3'h1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_power_on: assert property (up_r >= 3'h1 |-> power_lamp)
    else $error("power lamp dark");
  a_contact_follow: assert property (up_r >= 3'h4 |->
    rx_fault_contact == ~$past(rx_valid, 3)) else $error("contact wrong");
  a_tx_cut: assert property (up_r >= 3'h4 |->
    tx_enable == $past(rx_valid, 3)) else $error("transmit enable wrong");
  a_psu_lamp: assert property (up_r >= 3'h4 |->
    psu_lamp_red == ~$past(psu_online, 3)) else $error("supply lamp wrong");
  a_cu_yellow: assert property (up_r >= 3'h4 |->
    cu_yellow_lamp == $past(cu_rx, 3)) else $error("yellow lamp wrong");
  a_cu_green_off: assert property (up_r >= 3'h4 |->
    (cu_green_lamp & ~$past(cu_link, 3)) == 4'h0)
    else $error("green lamp lit without link");

  // Per-channel lamp checks.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    a_health_red: assert property (up_r >= 3'h4 &&
      !$past(rx_valid[c], 3) |-> health_lamp[c] == 2'b10)
      else $error("health lamp not red");
    a_traffic_off: assert property (up_r >= 3'h4 &&
      !$past(chan_active[c], 3) |-> traffic_lamp[c] == 2'b00)
      else $error("traffic lamp not off");
    a_traffic_idle: assert property (up_r >= 3'h4 &&
      $past(chan_active[c], 3) && !$past(tx_data[c], 3) &&
      !$past(rx_data[c], 3) |-> traffic_lamp[c] == 2'b01)
      else $error("idle traffic lamp not green");
  end
endmodule

bind fiber_node_status_indicators lamp_checker lamp_checker_inst (
  .mclk, .resetn, .rx_valid, .chan_active, .tx_data, .rx_data, .cu_link,
  .cu_rx, .psu_online, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .health_lamp,
  .traffic_lamp, .power_lamp, .cu_green_lamp, .cu_yellow_lamp,
  .psu_lamp_red, .rx_fault_contact, .tx_enable
);
`default_nettype wire

// ==== test/adjacent_node.sv ====
// Model of the neighbouring fiber nodes on both optical channels.
// Assumes the bench breaks a fiber through fiber_ok and asks for traffic.
`timescale 1ns/1ps
`default_nettype none
module adjacent_node (
  input  wire logic       mclk,
  input  wire logic [1:0] fiber_ok,
  input  wire logic [1:0] send,
  input  wire logic [1:0] tx_enable,
  output logic      [1:0] rx_valid,
  output logic      [1:0] rx_data,
  output logic      [1:0] nbr_fault
);
  // Light reaches the block only over an unbroken fiber.
  assign rx_valid = fiber_ok;
  // The neighbour loses light when our transmitter is cut.
  assign nbr_fault = ~tx_enable;
  initial rx_data = 2'b00;
  // A dark fiber carries noise, never a held level.
  always @(posedge mclk) begin
    for (int c = 0; c < 2; c++) begin
      rx_data[c] <= fiber_ok[c] ? send[c] : ~rx_data[c];
    end
  end
endmodule
`default_nettype wire

// ==== test/fiber_node_status_indicators_bench.sv ====
// Self-checking bench for the fiber node status-indicator block.
// Assumes the neighbour model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "lamp_cfg.svh"
module fiber_node_status_indicators_bench;
  logic mclk = 1'b0;
  logic resetn, net_break, fail_captured, fail_repaired, serial_master_seen;
  logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, power_lamp;
  logic [1:0] fiber_ok, send, chan_active, tx_data, psu_online, rx_valid;
  logic [1:0] rx_data, nbr_fault, tx_enable, psu_lamp_red, rx_fault_contact;
  logic [3:0] cu_link, cu_tx, cu_rx, wb_sel_i, cu_green_lamp, cu_yellow_lamp;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd_word;
  lamp_pkg::lamp_t [1:0] health_lamp, traffic_lamp;
  lamp_pkg::lamp_t       net_lamp;
  lamp_pkg::lamp_t [3:0] cu_dual_lamp;
  typedef struct {int what; logic [31:0] exp; logic [31:0] mask;} note_t;
  note_t q[$]; // Expected results, oldest first.
  int mismatches = 0;
  int n_compared = 0;
  event look;
  string names[12] = '{"health", "traffic", "net", "contact", "txen", "psu",
                       "cu_yel", "cu_grn", "nbr", "power", "rdata",
                       "cu_dual"};

  always #5 mclk = ~mclk;

  fiber_node_status_indicators fiber_node_status_indicators_inst (
    .mclk, .resetn, .rx_valid, .chan_active, .tx_data, .rx_data, .net_break,
    .fail_captured, .fail_repaired, .serial_master_seen, .cu_link, .cu_tx,
    .cu_rx, .psu_online, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .health_lamp, .traffic_lamp,
    .net_lamp, .power_lamp, .cu_dual_lamp, .cu_green_lamp, .cu_yellow_lamp,
    .psu_lamp_red, .rx_fault_contact, .tx_enable);
  adjacent_node adjacent_node_inst (.mclk, .fiber_ok, .send, .tx_enable,
    .rx_valid, .rx_data, .nbr_fault);

  // Picks the output that a note refers to.
  function automatic logic [31:0] observe(int what);
    case (what)
      0: return {28'h0, health_lamp};
      1: return {28'h0, traffic_lamp};
      2: return {30'h0, net_lamp};
      3: return {30'h0, rx_fault_contact};
      4: return {30'h0, tx_enable};
      5: return {30'h0, psu_lamp_red};
      6: return {28'h0, cu_yellow_lamp};
      7: return {28'h0, cu_green_lamp};
      8: return {30'h0, nbr_fault};
      9: return {31'h0, power_lamp};
      11: return {24'h0, cu_dual_lamp};
      default: return rd_word;
    endcase
  endfunction

  // Watcher: takes every waiting note, oldest first, and compares it with what is seen.
  always @(look) begin
    note_t n;
    logic [31:0] got;
    while (q.size() > 0) begin
      n = q.pop_front();
      got = observe(n.what);
      n_compared++;
      if ((got & n.mask) !== (n.exp & n.mask)) begin
        $display("Error %s expected %h seen %h", names[n.what], n.exp, got);
        mismatches++;
      end
    end
  end

  task automatic expect_val(int what, logic [31:0] exp, logic [31:0] mask);
    q.push_back('{what, exp, mask});
    -> look;
  endtask

  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // One classic Wishbone cycle; data is taken at the edge that sees ack.
  task automatic wb_xfer(logic we, logic [7:0] adr, logic [31:0] dat);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {24'h0, adr};
    wb_dat_i <= dat;
    // Waits for ack however long it takes; the watchdog ends a hang.
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    rd_word = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wb_read(logic [7:0] adr, logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    expect_val(10, exp, 32'hffff_ffff);
  endtask

  task automatic results();
    if (q.size() != 0) mismatches++; // Notes left uncompared count.
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: cuts a hung run short.
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results();
  end

  // Main sequence.
  initial begin
    logic [3:0] l, t, r;
    logic [1:0] p;
    logic [7:0] de, dm;
    void'($urandom(32'h6989));
    {resetn, net_break, fail_captured, fail_repaired} = 4'h0;
    {serial_master_seen, wb_we_i, wb_cyc_i, wb_stb_i} = 4'h0;
    {fiber_ok, send, chan_active, tx_data, psu_online} = 10'h0;
    {cu_link, cu_tx, cu_rx} = 12'h0;
    wb_sel_i = 4'hf;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    settle();
    expect_val(9, 32'h1, 32'h1);
    expect_val(1, 32'h0, 32'hf);
    wb_read(`ADDR_CTRL, `CTRL_RESET);
    wb_read(8'h10, 32'h0);
    $display("Test reset done");
    for (int f = 0; f < 4; f++) begin
      @(posedge mclk);
      fiber_ok <= f[1:0];
      settle();
      expect_val(0, {28'h0, f[1] ? 2'b01 : 2'b10, f[0] ? 2'b01 : 2'b10},
                 32'hf);
      expect_val(3, {30'h0, ~f[1:0]}, 32'h3);
      expect_val(4, {30'h0, f[1:0]}, 32'h3);
      expect_val(8, {30'h0, ~f[1:0]}, 32'h3);
    end
    $display("Test receive health done");
    @(posedge mclk);
    chan_active <= 2'b11;
    settle();
    expect_val(1, 32'h5, 32'hf);
    @(posedge mclk);
    tx_data <= 2'b01;
    settle();
    expect_val(1, 32'h4, 32'he);
    @(posedge mclk);
    tx_data <= 2'b00;
    send <= 2'b10;
    settle();
    expect_val(1, 32'h1, 32'hf);
    $display("Test traffic done");
    wb_xfer(1'b1, `ADDR_CTRL, 32'h0);
    settle();
    expect_val(2, 32'h0, 32'h3);
    wb_xfer(1'b1, `ADDR_CTRL, 32'h3);
    settle();
    expect_val(2, 32'h1, 32'h3);
    @(posedge mclk);
    net_break <= 1'b1;
    settle();
    expect_val(2, 32'h0, 32'h2);
    wb_xfer(1'b1, `ADDR_CTRL, 32'hb);
    @(posedge mclk);
    fail_captured <= 1'b1;
    settle();
    expect_val(2, 32'h0, 32'h1);
    wb_xfer(1'b1, `ADDR_CTRL, 32'h1b);
    wb_read(`ADDR_CTRL, 32'hb);
    wb_xfer(1'b1, `ADDR_CTRL, 32'h27);
    @(posedge mclk);
    serial_master_seen <= 1'b1;
    settle();
    expect_val(2, 32'h2, 32'h3);
    @(posedge mclk);
    serial_master_seen <= 1'b0;
    wb_xfer(1'b1, `ADDR_CTRL, 32'hb);
    settle();
    expect_val(2, 32'h2, 32'h3);
    wb_xfer(1'b0, `ADDR_STATUS, 32'h0);
    expect_val(10, 32'h40, 32'h7f);
    wb_read(`ADDR_LAMPS, 32'h0000_518c);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    settle();
    expect_val(2, 32'h0, 32'h3);
    wb_read(`ADDR_CTRL, `CTRL_RESET);
    $display("Test network lamp done");
    for (int i = 0; i < 8; i++) begin
      l = 4'($urandom());
      t = 4'($urandom());
      r = 4'($urandom());
      p = 2'($urandom());
      @(posedge mclk);
      {cu_link, cu_tx, cu_rx, psu_online} <= {l, t, r, p};
      settle();
      expect_val(6, {28'h0, r}, 32'hf);
      expect_val(7, {28'h0, l & ~t & ~r}, {28'h0, ~l | (~t & ~r)});
      expect_val(5, {30'h0, ~p}, 32'h3);
      for (int k = 0; k < 4; k++) begin
        de[2*k]   = l[k] & ~t[k] & ~r[k];
        dm[2*k]   = ~l[k] | (~t[k] & ~r[k]);
        de[2*k+1] = 1'b0;
        dm[2*k+1] = ~(l[k] & r[k]);
      end
      expect_val(11, {24'h0, de}, {24'h0, dm});
    end
    $display("Test copper and supply done");
    @(posedge mclk);
    results();
  end
endmodule
`default_nettype wire
